// *** rtl/sim_params.svh ***
// How it works
// - mask bit 6 promotes PLL lock flag
// - mask bit 5 promotes current limit flag
// - mask bit 4 promotes internal oscillator fault
// - mask bit 3 promotes main oscillator fault
// - mask bit 2 promotes regulator unregulated flag
// - mask bit 1 promotes brown-out flag
// - mask bit 0 promotes PLL fault flag
// - bits 31 to 7 reserved, read zero
// - masked status equals raw AND mask AND brown-out select gate
// - write one clears masked and raw bit
// - brown-out masked needs select bit cleared
// - PLL lock set by ready timer event
// - PLL fault set when PLL stops
// - raw flags set only by hardware detectors
`ifndef SIM_PARAMS_SVH
`define SIM_PARAMS_SVH
`define SIM_RAW_OFFSET 12'h050
`define SIM_MASK_OFFSET 12'h054
`define SIM_MASKED_OFFSET 12'h058
`define SIM_CTRL_OFFSET 12'h070
`define SIM_NUM_SRC 7
`define SIM_MASK_RESET 7'h00
`define SIM_RAW_RESET 7'h00
`define SIM_BOR_BIT 1
`define SIM_PLL_LOCK_BIT 6
`define SIM_PLL_FAULT_BIT 0
`define SIM_SEL_BIT 0
`endif

// *** rtl/sim_pkg.sv ***
`include "sim_params.svh"
package sim_pkg;
    typedef logic [`SIM_NUM_SRC-1:0] sim_src_type;
    typedef enum logic [1:0] {
        SIM_SEL_RAW,
        SIM_SEL_MASK,
        SIM_SEL_MASKED,
        SIM_SEL_CTRL
    } sim_reg_sel_type;
endpackage

// *** rtl/sim_flag_if.sv ***
`timescale 1ns/1ps
interface sim_flag_if;
    import sim_pkg::*;
    sim_src_type event_set;
    sim_src_type clear;
    sim_src_type raw;
    modport ctrl (output event_set, output clear, input raw);
    modport flags (input event_set, input clear, output raw);
endinterface

// *** rtl/sim_raw_flags.sv ***
`timescale 1ns/1ps
`include "sim_params.svh"
module sim_raw_flags
    import sim_pkg::*;
(
    input wire logic clock_in,         // system clock
    input wire logic rst_in,           // async reset, active high
    input wire logic enable_in,        // clock enable
    sim_flag_if.flags flag_port        // set, clear and state
);
    sim_src_type raw;
    sim_src_type next_raw;
    // a detector event in the clearing cycle survives: set wins
    assign next_raw = flag_port.event_set | (raw & ~flag_port.clear);
    assign flag_port.raw = raw;

    genvar i;
    generate
        for (i = 0; i < `SIM_NUM_SRC; i++) begin : g_flag
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    raw[i] <= 1'b0;
                end else if (enable_in) begin
                    raw[i] <= next_raw[i];
                end
            end
        end
    endgenerate
endmodule

// *** rtl/sim_irq_ctrl.sv ***
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "sim_params.svh"
module sim_irq_ctrl
    import sim_pkg::*;
(
    input wire logic clock_in,          // system clock, 40 MHz
    input wire logic rst_in,            // async reset, active high
    input wire logic enable_in,         // clock enable, freezes all state when low
    input wire logic [6:0] detect_in,   // detector pins: lock,curlim,iosc,mosc,ldo,bor,pllf
    input wire logic psel_in,           // apb select
    input wire logic penable_in,        // apb enable
    input wire logic pwrite_in,         // apb write
    input wire logic [11:0] paddr_in,   // apb byte address
    input wire logic [31:0] pwdata_in,  // apb write data
    output logic [31:0] prdata_out,     // apb read data
    output logic pready_out,            // apb ready
    output logic pslverr_out,           // apb error on unmapped address
    output logic irq_out                // level interrupt request
);
    // detectors live in other domains, so sync twice before use
    sim_src_type det_meta;
    sim_src_type det_sync;
    sim_src_type det_prev;
    sim_src_type det_rise;

    sim_src_type mask;
    logic brownout_irq_or_reset_sel;
    sim_src_type masked;
    sim_src_type w1c;
    sim_flag_if flag_bus ();

    wire access_setup = psel_in & ~penable_in;
    wire access_done = psel_in & penable_in & pready_out;
    wire wr_done = access_done & pwrite_in;
    wire [11:0] word_addr = {paddr_in[11:2], 2'b00};
    wire hit_raw = word_addr == `SIM_RAW_OFFSET;
    wire hit_mask = word_addr == `SIM_MASK_OFFSET;
    wire hit_masked = word_addr == `SIM_MASKED_OFFSET;
    wire hit_ctrl = word_addr == `SIM_CTRL_OFFSET;
    wire hit_any = hit_raw | hit_mask | hit_masked | hit_ctrl;

    function automatic sim_reg_sel_type decode_sel(input logic r, input logic m, input logic c);
        decode_sel = r ? SIM_SEL_RAW : (m ? SIM_SEL_MASK : (c ? SIM_SEL_CTRL : SIM_SEL_MASKED));
    endfunction

    wire sim_reg_sel_type rd_sel = decode_sel(hit_raw, hit_mask, hit_ctrl);

    // event on rising edge of a detector level; a held level does not re-set after clear
    assign det_rise = det_sync & ~det_prev;
    assign flag_bus.event_set = det_rise;

    // only masked bits are clearable, so clearing acts through the masked view
    assign w1c = (wr_done && hit_masked) ? (pwdata_in[`SIM_NUM_SRC-1:0] & masked) : '0;
    assign flag_bus.clear = w1c;

    // brown-out only reports while the select steers it to an interrupt
    wire sim_src_type gate = {{(`SIM_NUM_SRC-2){1'b1}}, ~brownout_irq_or_reset_sel, 1'b1};
    assign masked = flag_bus.raw & mask & gate;
    wire next_irq = |masked;

    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (rd_sel)
            SIM_SEL_RAW: rd_word[`SIM_NUM_SRC-1:0] = flag_bus.raw;
            SIM_SEL_MASK: rd_word[`SIM_NUM_SRC-1:0] = mask;
            SIM_SEL_MASKED: rd_word[`SIM_NUM_SRC-1:0] = masked;
            SIM_SEL_CTRL: rd_word[`SIM_SEL_BIT] = brownout_irq_or_reset_sel;
        endcase
    end

    sim_raw_flags u_flags (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .enable_in(enable_in),
        .flag_port(flag_bus.flags)
    );

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            det_meta <= '0;
            det_sync <= '0;
            det_prev <= '0;
        end else if (enable_in) begin
            det_meta <= detect_in;
            det_sync <= det_meta;
            det_prev <= det_sync;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mask <= `SIM_MASK_RESET;
            brownout_irq_or_reset_sel <= 1'b0;
        end else if (enable_in && wr_done) begin
            // reserved bits 31..7 are dropped on write and read back zero
            if (hit_mask) begin
                mask <= pwdata_in[`SIM_NUM_SRC-1:0];
            end
            if (hit_ctrl) begin
                brownout_irq_or_reset_sel <= pwdata_in[`SIM_SEL_BIT];
            end
        end
    end

    // no wait state: ready rises in the first access cycle, data registered with it
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
            irq_out <= 1'b0;
        end else if (enable_in) begin
            irq_out <= next_irq;
            pready_out <= access_setup;
            pslverr_out <= access_setup & ~hit_any;
            if (access_setup) begin
                prdata_out <= (hit_any && !pwrite_in) ? rd_word : 32'h0000_0000;
            end
        end
    end
endmodule

// *** bench/sim_irq_ctrl_asserts.sv ***
`timescale 1ns/1ps
module sim_irq_ctrl_asserts(
    input wire logic clock_in, rst_in, enable_in, psel_in, penable_in, pwrite_in,
    input wire logic [6:0] detect_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in, prdata_out,
    input wire logic pready_out, pslverr_out, irq_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    wire logic mapped = paddr_in[11:2] inside {10'h014, 10'h015, 10'h016, 10'h01C};
    wire logic mask_zero = enable_in && pready_out && pwrite_in && paddr_in[11:2] == 10'h015
        && pwdata_in[6:0] == 7'h00;
    sequence setup_s;
        psel_in && !penable_in && enable_in;
    endsequence
    AST_READY: assert property (setup_s |=> pready_out) else $error("no ready after setup");
    AST_PULSE: assert property (pready_out && enable_in |=> !pready_out) else $error("ready too long");
    AST_IDLE: assert property (!psel_in && enable_in |=> !pready_out) else $error("ready while idle");
    AST_ERR_RDY: assert property (pslverr_out |-> pready_out) else $error("error without ready");
    AST_UNMAPPED: assert property (setup_s ##0 !mapped |=> pslverr_out) else $error("no error");
    AST_MAPPED: assert property (setup_s ##0 mapped |=> !pslverr_out) else $error("false error");
    AST_RESV: assert property (pready_out && !pwrite_in |-> prdata_out[31:7] == 25'h0) else $error("resv");
    AST_ERR_ZERO: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0) else $error("err data");
    AST_MASK_OFF: assert property (mask_zero |-> ##2 !irq_out) else $error("irq with masks off");
endmodule
bind sim_irq_ctrl sim_irq_ctrl_asserts u_chk (.*);

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic clk = 0, rst = 1, en = 1, psel = 0, pen = 0, pwr = 0, prdy, perr, irq, err;
    logic [6:0] det = 0, m;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, v, seed = 32'h5BE5;
    int errors = 0, tests_run = 0, cyc = 0;
    sim_irq_ctrl u_dut (.clock_in(clk), .rst_in(rst), .enable_in(en), .detect_in(det), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(prdy), .pslverr_out(perr), .irq_out(irq));
    initial forever #12.5 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] exp_masked(logic [6:0] raw, mk, logic sel);
        return {25'h0, raw & mk & ~{5'h0, sel, 1'b0}};
    endfunction
    task chk(logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 50);
        if (n >= 50)
            errors++;
        rd = prdata;
        err = perr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ceiling far above the few hundred cycles the sequence needs
    always @(posedge clk) if (++cyc > 20000) begin
        errors++;
        tally_and_finish;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            apb(0, i == 3 ? 12'h070 : 12'h050 + 12'(4 * i), 0);
            chk(rd, 0);
        end
        apb(1, 12'h050, 32'hFFFFFFFF);
        apb(0, 12'h050, 0);
        chk(rd, 0);
        apb(0, 12'h05C, 0);
        chk({rd[30:0], err}, 1);
        repeat (8) begin
            v = rnd();
            apb(1, 12'h054, v);
            apb(0, 12'h054, 0);
            chk(rd, {25'h0, v[6:0]});
        end
        $display("register tests done");
        for (int k = 0; k < 7; k++) begin
            m = 7'h01 << k;
            apb(1, 12'h054, m);
            det <= m;
            repeat (6) @(posedge clk);
            chk(irq, 1);
            apb(0, 12'h058, 0);
            chk(rd, exp_masked(m, m, 0));
            apb(1, 12'h070, 1);
            apb(0, 12'h058, 0);
            chk(rd, exp_masked(m, m, 1));
            apb(1, 12'h070, 0);
            apb(1, 12'h054, 0);
            repeat (2) @(posedge clk);
            chk(irq, 0);
            apb(0, 12'h050, 0);
            chk(rd, {25'h0, m});
            apb(1, 12'h054, m);
            apb(1, 12'h058, {25'h0, m});
            repeat (2) @(posedge clk);
            chk(irq, 0);
            apb(0, 12'h050, 0);
            chk(rd, 0);
            det <= 0;
            $display("source %0d done", k);
        end
        // clock enable low must freeze the detector path and the flags
        apb(1, 12'h054, 32'h0000_007F);
        en <= 0;
        det <= 7'h7F;
        repeat (8) @(posedge clk);
        chk(irq, 0);
        en <= 1;
        repeat (6) @(posedge clk);
        chk(irq, 1);
        apb(1, 12'h058, 0);
        chk(irq, 1);
        // mid-run reset with detectors idle, so no fresh edge follows release
        det <= 0;
        rst <= 1;
        repeat (2) @(posedge clk);
        chk(irq, 0);
        rst <= 0;
        @(posedge clk);
        apb(0, 12'h054, 0);
        chk(rd, 0);
        apb(0, 12'h050, 0);
        chk(rd, 0);
        $display("enable and reset tests done");
        tally_and_finish;
    end
endmodule
